// file: verilog/cer_consts.vh
// Register offsets, field positions, reset values and widths of the cache event and error block.
`ifndef CER_CONSTS_VH
`define CER_CONSTS_VH
`define CER_ADDR_W 12
`define CER_OFF_AUX_CTRL 12'h000
`define CER_OFF_DBG_CTRL 12'h004
`define CER_OFF_IRQ_RAW 12'h008
`define CER_OFF_IRQ_CLR 12'h00C
`define CER_OFF_EVT_CTRL 12'h010
`define CER_AUX_EVT_BUS_EN 0
`define CER_DBG_SECURE_EN 2
`define CER_AUX_RESET 32'h00000000
`define CER_IRQ_N 9
`define CER_IRQ_DECODE 0
`define CER_IRQ_SLAVE 1
`define CER_IRQ_DATA_RD 2
`define CER_IRQ_TAG_RD 3
`define CER_IRQ_DATA_WR 4
`define CER_IRQ_TAG_WR 5
`define CER_IRQ_DATA_PAR 6
`define CER_IRQ_TAG_PAR 7
`define CER_IRQ_EVT_CNT 8
`define CER_EVT_N 19
`define CER_TAG_ERR_N 8
`define CER_RESP_OKAY 2'h0
`define CER_RESP_SLVERR 2'h2
`define CER_OP_READ 2'h0
`define CER_OP_WRITE 2'h1
`define CER_OP_MAINT 2'h2
`define CER_OP_SBUF 2'h3
`endif

// file: verilog/cer_event_error.v
// Cache event bus, sticky error interrupts, RAM parity and APB registers.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "cer_consts.vh"

// Behaviour
// (RQ1) Event outputs pulse one cycle per event
// (RQ2) Secure debug low: only non-secure events shown
// (RQ3) Secure debug high: secure and non-secure shown
// (RQ4) Secure debug synchronised, readable in debug register
// (RQ5) Software syncs cache before secure-debug analysis
// (RQ6) Events only when bus enable bit set
// (RQ7) Eviction, data read/write lookups and hits
// (RQ8) Hint received per port, hint hit, alloc
// (RQ9) Speculative read received and confirmed per port
// (RQ10) Instruction lookup/hit, internal prefetch, write allocate
// (RQ11) Interrupt lines are sticky
// (RQ12) Combined interrupt is OR of nine
// (RQ13) Decode, slave error and counter interrupts
// (RQ14) Six RAM read/write/parity error interrupts
// (RQ15) One data parity bit per byte
// (RQ16) One shared tag parity bit
// (RQ17) RAM error inputs treated as parity errors
// (RQ18) Read parity error gives SLVERR and event
// (RQ19) Write parity error raises slave error interrupt
// (RQ20) Maintenance parity error: interrupts only
// (RQ21) Cacheable read tag/data errors raise tag-read lines
// (RQ22) Store-buffer tag error: interrupt, abandon write
// (RQ23) Store-buffer data write error: interrupt, stays dirty
// (RQ24) Interrupts held until software clear or reset
module cer_event_error #(
    parameter DATA_W = 64,
    parameter TAG_W = 21
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`CER_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire secure_debug_enable,
    input wire [`CER_EVT_N-1:0] event_raw,
    input wire [`CER_EVT_N-1:0] event_secure,
    input wire event_counter_hit,
    input wire master_decode_error,
    input wire master_slave_error,
    input wire [DATA_W-1:0] data_ram_wdata,
    input wire [TAG_W-1:0] tag_ram_wdata,
    input wire data_ram_par_err,
    input wire tag_ram_par_err,
    input wire data_ram_error_in,
    input wire [`CER_TAG_ERR_N-1:0] tag_ram_error_in,
    input wire ram_check_valid,
    input wire ram_check_is_write,
    input wire [1:0] ram_op,
    input wire write_back_access,
    output reg [DATA_W/8-1:0] data_ram_parity,
    output reg tag_ram_parity,
    output reg [1:0] slave_read_response,
    output reg parity_error_event,
    output reg sbuf_write_abandon,
    output reg sbuf_line_dirty,
    output reg eviction_event,
    output reg data_read_lookup_event,
    output reg data_read_hit_event,
    output reg data_write_lookup_event,
    output reg data_write_hit_event,
    output reg write_through_lookup_event,
    output reg hint_received_port0_event,
    output reg hint_received_port1_event,
    output reg hint_hit_event,
    output reg hint_alloc_event,
    output reg spec_read_received_port0,
    output reg spec_read_received_port1,
    output reg spec_read_confirmed_port0,
    output reg spec_read_confirmed_port1,
    output reg instr_read_lookup_event,
    output reg instr_read_hit_event,
    output reg internal_prefetch_alloc_event,
    output reg write_allocate_event,
    output reg decode_error_irq,
    output reg slave_error_irq,
    output reg data_ram_read_error_irq,
    output reg tag_ram_read_error_irq,
    output reg data_ram_write_error_irq,
    output reg tag_ram_write_error_irq,
    output reg data_parity_error_irq,
    output reg tag_parity_error_irq,
    output reg event_counter_irq,
    output reg combined_irq
);

    // Even parity over each byte lane of a data word.
    function [DATA_W/8-1:0] byte_parity;
        input [DATA_W-1:0] d;
        integer i;
        begin
            for (i = 0; i < DATA_W/8; i = i + 1) begin
                byte_parity[i] = ^d[i*8 +: 8];
            end
        end
    endfunction

    reg secure_sync1;
    reg secure_sync2;
    reg evt_bus_en;
    reg [`CER_IRQ_N-1:0] irq_q;
    reg [`CER_IRQ_N-1:0] irq_clear;
    reg [`CER_IRQ_N-1:0] irq_set;
    reg [`CER_IRQ_N-1:0] next_irq;
    reg [`CER_EVT_N-1:0] next_evt;
    reg [31:0] next_rdata;
    reg addr_ok;
    wire apb_access;
    wire apb_write;
    wire tag_err_any;
    wire data_err_any;
    wire read_err;

    assign apb_access = psel & penable & ~pready;
    // A write lands only at the edge that completes the transfer, so an
    // access held in its wait state never changes a register early.
    assign apb_write = psel & penable & pready & pwrite;
    // A RAM error strobe counts as a parity error in these merged error flags.
    assign tag_err_any = tag_ram_par_err | (|tag_ram_error_in); // RQ17
    assign data_err_any = data_ram_par_err | data_ram_error_in; // RQ17
    assign read_err = ram_check_valid & (ram_op == `CER_OP_READ) &
        (tag_err_any | data_err_any); // RQ18

    // Only the second flop is read, so metastability never reaches logic.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secure_sync1 <= 1'b0;
            secure_sync2 <= 1'b0;
        end else begin
            secure_sync1 <= secure_debug_enable; // RQ4
            secure_sync2 <= secure_sync1; // RQ4
        end
    end

    // Inputs arrive as one-cycle strobes, so one register stage keeps
    // each output pulse exactly one cycle wide.
    always @* begin
        next_evt = event_raw &
            ~(event_secure & {`CER_EVT_N{~secure_sync2}}); // RQ2 RQ3
        // The read error carries no security tag, so secure debug never masks it.
        if (read_err) begin
            next_evt[18] = 1'b1; // RQ18
        end
        if (!evt_bus_en) begin
            next_evt = {`CER_EVT_N{1'b0}}; // RQ6
        end
    end

    // Each event output is its own flop, so a monitor sees clean pulses.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eviction_event <= 1'b0;
            data_read_lookup_event <= 1'b0;
            data_read_hit_event <= 1'b0;
            data_write_lookup_event <= 1'b0;
            data_write_hit_event <= 1'b0;
            write_through_lookup_event <= 1'b0;
            hint_received_port0_event <= 1'b0;
            hint_received_port1_event <= 1'b0;
            hint_hit_event <= 1'b0;
            hint_alloc_event <= 1'b0;
            spec_read_received_port0 <= 1'b0;
            spec_read_received_port1 <= 1'b0;
            spec_read_confirmed_port0 <= 1'b0;
            spec_read_confirmed_port1 <= 1'b0;
            instr_read_lookup_event <= 1'b0;
            instr_read_hit_event <= 1'b0;
            internal_prefetch_alloc_event <= 1'b0;
            write_allocate_event <= 1'b0;
            parity_error_event <= 1'b0;
        end else begin
            eviction_event <= next_evt[0]; // RQ1 RQ7
            data_read_lookup_event <= next_evt[1];
            data_read_hit_event <= next_evt[2];
            data_write_lookup_event <= next_evt[3];
            data_write_hit_event <= next_evt[4];
            write_through_lookup_event <= next_evt[5];
            hint_received_port0_event <= next_evt[6]; // RQ8
            hint_received_port1_event <= next_evt[7];
            hint_hit_event <= next_evt[8];
            hint_alloc_event <= next_evt[9];
            spec_read_received_port0 <= next_evt[10]; // RQ9
            spec_read_received_port1 <= next_evt[11];
            spec_read_confirmed_port0 <= next_evt[12];
            spec_read_confirmed_port1 <= next_evt[13];
            instr_read_lookup_event <= next_evt[14]; // RQ10
            instr_read_hit_event <= next_evt[15];
            internal_prefetch_alloc_event <= next_evt[16];
            write_allocate_event <= next_evt[17];
            parity_error_event <= next_evt[18]; // RQ18
        end
    end

    // Routing of RAM errors to interrupt causes by operation type.
    always @* begin
        irq_set = {`CER_IRQ_N{1'b0}};
        irq_set[`CER_IRQ_DECODE] = master_decode_error; // RQ13
        irq_set[`CER_IRQ_SLAVE] = master_slave_error; // RQ13
        irq_set[`CER_IRQ_EVT_CNT] = event_counter_hit; // RQ13
        if (ram_check_valid) begin
            if (ram_check_is_write) begin
                irq_set[`CER_IRQ_DATA_WR] = data_ram_error_in; // RQ14 RQ23
                irq_set[`CER_IRQ_TAG_WR] = |tag_ram_error_in; // RQ14
            end else begin
                irq_set[`CER_IRQ_TAG_PAR] = tag_ram_par_err | // RQ21 RQ22
                    (ram_op == `CER_OP_READ && data_ram_error_in);
                irq_set[`CER_IRQ_TAG_RD] = |tag_ram_error_in | // RQ14 RQ21
                    (ram_op == `CER_OP_READ && data_ram_error_in);
                if (ram_op != `CER_OP_READ) begin
                    irq_set[`CER_IRQ_DATA_PAR] = data_ram_par_err; // RQ14 RQ20
                    irq_set[`CER_IRQ_DATA_RD] = data_ram_error_in; // RQ14
                end
            end
            if (ram_op == `CER_OP_WRITE && (tag_err_any || data_err_any)) begin
                irq_set[`CER_IRQ_SLAVE] = 1'b1; // RQ19
            end
        end
    end

    // Set wins over a clear in the same cycle so no event is lost.
    always @* begin
        next_irq = (irq_q & ~irq_clear) | irq_set; // RQ11 RQ24
    end

    // The combined line is built from the same next value as the nine
    // lines, so it never lags them by a cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= {`CER_IRQ_N{1'b0}};
            decode_error_irq <= 1'b0;
            slave_error_irq <= 1'b0;
            data_ram_read_error_irq <= 1'b0;
            tag_ram_read_error_irq <= 1'b0;
            data_ram_write_error_irq <= 1'b0;
            tag_ram_write_error_irq <= 1'b0;
            data_parity_error_irq <= 1'b0;
            tag_parity_error_irq <= 1'b0;
            event_counter_irq <= 1'b0;
            combined_irq <= 1'b0;
        end else begin
            irq_q <= next_irq; // RQ11
            decode_error_irq <= next_irq[`CER_IRQ_DECODE];
            slave_error_irq <= next_irq[`CER_IRQ_SLAVE];
            data_ram_read_error_irq <= next_irq[`CER_IRQ_DATA_RD];
            tag_ram_read_error_irq <= next_irq[`CER_IRQ_TAG_RD];
            data_ram_write_error_irq <= next_irq[`CER_IRQ_DATA_WR];
            tag_ram_write_error_irq <= next_irq[`CER_IRQ_TAG_WR];
            data_parity_error_irq <= next_irq[`CER_IRQ_DATA_PAR];
            tag_parity_error_irq <= next_irq[`CER_IRQ_TAG_PAR];
            event_counter_irq <= next_irq[`CER_IRQ_EVT_CNT];
            combined_irq <= |next_irq; // RQ12
        end
    end

    // Parity and read-response outputs, registered with the RAM pipeline.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ram_parity <= {DATA_W/8{1'b0}};
            tag_ram_parity <= 1'b0;
            slave_read_response <= `CER_RESP_OKAY;
            sbuf_write_abandon <= 1'b0;
            sbuf_line_dirty <= 1'b0;
        end else begin
            data_ram_parity <= byte_parity(data_ram_wdata); // RQ15
            tag_ram_parity <= ^tag_ram_wdata; // RQ16
            slave_read_response <= `CER_RESP_OKAY;
            sbuf_write_abandon <= 1'b0;
            sbuf_line_dirty <= 1'b0;
            if (read_err) begin
                slave_read_response <= `CER_RESP_SLVERR; // RQ18
            end
            if (ram_check_valid && ram_op == `CER_OP_SBUF) begin
                sbuf_write_abandon <= !ram_check_is_write && tag_err_any; // RQ22
                // A failed data write still leaves a write-back line dirty.
                sbuf_line_dirty <= ram_check_is_write && write_back_access; // RQ23
            end
        end
    end

    // APB slave: one wait state, then pready pulses for one cycle.
    always @* begin
        addr_ok = 1'b1;
        next_rdata = 32'h00000000;
        case (paddr)
            `CER_OFF_AUX_CTRL: begin
                next_rdata[`CER_AUX_EVT_BUS_EN] = evt_bus_en;
            end
            `CER_OFF_DBG_CTRL: begin
                next_rdata[`CER_DBG_SECURE_EN] = secure_sync2; // RQ4
            end
            `CER_OFF_IRQ_RAW: begin
                next_rdata[`CER_IRQ_N-1:0] = irq_q;
            end
            `CER_OFF_IRQ_CLR: begin
                next_rdata = 32'h00000000;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    always @* begin
        irq_clear = {`CER_IRQ_N{1'b0}};
        if (apb_write && paddr == `CER_OFF_IRQ_CLR) begin
            irq_clear = pwdata[`CER_IRQ_N-1:0]; // RQ24
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_bus_en <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access & ~addr_ok;
            prdata <= 32'h00000000;
            if (apb_access && !pwrite) begin
                prdata <= next_rdata;
            end
            if (apb_write && paddr == `CER_OFF_AUX_CTRL) begin
                evt_bus_en <= pwdata[`CER_AUX_EVT_BUS_EN]; // RQ6
            end
        end
    end

endmodule

// file: tb/cer_event_error_monitor.sv
// Assertion checker bound to the cache event and error block.
`timescale 1ns/1ps
`include "cer_consts.vh"
module cer_event_error_monitor #(
    parameter DATA_W = 64,
    parameter TAG_W = 21
) (
    input wire pclk, presetn, psel, penable, pwrite,
    input wire [`CER_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [`CER_EVT_N-1:0] event_raw,
    input wire [DATA_W-1:0] data_ram_wdata,
    input wire data_ram_par_err, tag_ram_par_err, ram_check_valid,
    input wire ram_check_is_write,
    input wire [1:0] ram_op, slave_read_response,
    input wire [DATA_W/8-1:0] data_ram_parity,
    input wire sbuf_write_abandon, eviction_event, decode_error_irq,
    input wire slave_error_irq, master_decode_error, tag_parity_error_irq,
    input wire data_ram_read_error_irq, tag_ram_read_error_irq,
    input wire data_ram_write_error_irq, tag_ram_write_error_irq,
    input wire data_parity_error_irq, event_counter_irq, combined_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire clr = psel && penable && pwrite &&
        paddr == `CER_OFF_IRQ_CLR && pwdata[`CER_IRQ_DECODE];
    wire perr = data_ram_par_err || tag_ram_par_err;
    sequence s_rd_err;
        ram_check_valid && !ram_check_is_write &&
            ram_op == `CER_OP_READ && perr;
    endsequence
    sequence s_sbuf_tag;
        ram_check_valid && !ram_check_is_write &&
            ram_op == `CER_OP_SBUF && tag_ram_par_err;
    endsequence
    function automatic [DATA_W/8-1:0] bpar(input [DATA_W-1:0] d);
        integer i;
        for (i = 0; i < DATA_W/8; i = i + 1) begin
            bpar[i] = ^d[i*8 +: 8];
        end
    endfunction
    a_evt_cause: assert property (
        eviction_event |-> $past(event_raw[0]))
        else $error("Eviction pulse without strobe.");
    // The guard skips the first edge, where outputs still hold reset values.
    a_data_parity: assert property (
        $past(presetn) |-> data_ram_parity == bpar($past(data_ram_wdata)))
        else $error("Data parity mismatch.");
    a_irq_sticky: assert property (
        $fell(decode_error_irq) |-> $past(clr) || $past(clr, 2))
        else $error("Decode interrupt dropped without clear.");
    a_decode_set: assert property (
        master_decode_error |=> decode_error_irq)
        else $error("Decode interrupt not raised.");
    a_read_slverr: assert property (s_rd_err |=>
        slave_read_response == `CER_RESP_SLVERR)
        else $error("Read parity error without error response.");
    a_write_slv_irq: assert property (
        ram_check_valid && ram_op == `CER_OP_WRITE && perr |=> slave_error_irq)
        else $error("Write parity error without slave interrupt.");
    a_maint_no_resp: assert property (
        ram_check_valid && ram_op == `CER_OP_MAINT |=>
            slave_read_response == `CER_RESP_OKAY)
        else $error("Maintenance error reached the read response.");
    a_sbuf_abandon: assert property (s_sbuf_tag |=>
        sbuf_write_abandon && tag_parity_error_irq)
        else $error("Store buffer tag error not handled.");
    a_combined_or: assert property (
        combined_irq == (decode_error_irq || slave_error_irq ||
            data_ram_read_error_irq || tag_ram_read_error_irq ||
            data_ram_write_error_irq || tag_ram_write_error_irq ||
            data_parity_error_irq || tag_parity_error_irq ||
            event_counter_irq))
        else $error("Combined interrupt differs from its lines.");
endmodule
bind cer_event_error cer_event_error_monitor #(
    .DATA_W(DATA_W), .TAG_W(TAG_W)
) u_mon (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .event_raw, .data_ram_wdata, .data_ram_par_err, .tag_ram_par_err,
    .ram_check_valid, .ram_check_is_write, .ram_op, .slave_read_response,
    .data_ram_parity, .sbuf_write_abandon, .eviction_event,
    .decode_error_irq, .slave_error_irq, .master_decode_error,
    .tag_parity_error_irq, .data_ram_read_error_irq, .tag_ram_read_error_irq,
    .data_ram_write_error_irq, .tag_ram_write_error_irq,
    .data_parity_error_irq, .event_counter_irq, .combined_irq
);

// file: tb/cer_irq_sink.sv
// Far-side model: interrupt controller and trace collector.
`timescale 1ns/1ps
module cer_irq_sink (
    input wire pclk,
    input wire presetn,
    input wire combined_irq,
    input wire evt,
    output reg [7:0] evt_count,
    output reg irq_seen
);
    // Sampling once per edge counts a one-cycle pulse exactly once.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_count <= 8'h00;
            irq_seen <= 1'b0;
        end else begin
            evt_count <= evt_count + {7'h00, evt};
            irq_seen <= combined_irq;
        end
    end
endmodule

// file: tb/cer_event_error_tb_top.sv
// Self-checking bench for the cache event and error block.
`timescale 1ns/1ps
`include "cer_consts.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin \
    n_mismatch++; $display("[ERR] %0t %h %h", $time, a, b); end end
module cer_event_error_tb_top;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h00000000;
    reg sde = 1'b0;
    reg [18:0] ev = 19'h00000;
    reg [18:0] sec = 19'h00000;
    reg [2:0] cause = 3'h0;
    reg [63:0] dwd = 64'h0;
    reg [20:0] twd = 21'h0;
    reg [8:0] rc = 9'h000;
    wire [31:0] prdata;
    wire pready, pslverr, tpar, abandon, dirty, comb, sink_irq;
    wire [7:0] dpar, sink_cnt;
    wire [1:0] rresp;
    wire [18:0] evo;
    wire [8:0] irq;
    integer n_mismatch = 0;
    integer compares = 0;
    integer i;
    reg [31:0] rd;
    reg err;
    reg [8:0] xirq;
    always #10 pclk = ~pclk;
    cer_event_error u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .secure_debug_enable(sde),
        .event_raw(ev), .event_secure(sec), .event_counter_hit(cause[0]),
        .master_decode_error(cause[1]), .master_slave_error(cause[2]),
        .data_ram_wdata(dwd), .tag_ram_wdata(twd),
        .data_ram_par_err(rc[2]), .tag_ram_par_err(rc[3]),
        .data_ram_error_in(rc[4]), .tag_ram_error_in({7'h00, rc[5]}),
        .ram_check_valid(rc[0]), .ram_check_is_write(rc[1]),
        .ram_op(rc[8:7]), .write_back_access(rc[6]),
        .data_ram_parity(dpar), .tag_ram_parity(tpar),
        .slave_read_response(rresp), .parity_error_event(evo[18]),
        .sbuf_write_abandon(abandon), .sbuf_line_dirty(dirty),
        .eviction_event(evo[0]), .data_read_lookup_event(evo[1]),
        .data_read_hit_event(evo[2]), .data_write_lookup_event(evo[3]),
        .data_write_hit_event(evo[4]),
        .write_through_lookup_event(evo[5]),
        .hint_received_port0_event(evo[6]),
        .hint_received_port1_event(evo[7]),
        .hint_hit_event(evo[8]), .hint_alloc_event(evo[9]),
        .spec_read_received_port0(evo[10]),
        .spec_read_received_port1(evo[11]),
        .spec_read_confirmed_port0(evo[12]),
        .spec_read_confirmed_port1(evo[13]),
        .instr_read_lookup_event(evo[14]), .instr_read_hit_event(evo[15]),
        .internal_prefetch_alloc_event(evo[16]),
        .write_allocate_event(evo[17]),
        .decode_error_irq(irq[0]), .slave_error_irq(irq[1]),
        .data_ram_read_error_irq(irq[2]), .tag_ram_read_error_irq(irq[3]),
        .data_ram_write_error_irq(irq[4]), .tag_ram_write_error_irq(irq[5]),
        .data_parity_error_irq(irq[6]), .tag_parity_error_irq(irq[7]),
        .event_counter_irq(irq[8]), .combined_irq(comb)
    );
    cer_irq_sink u_sink (.pclk, .presetn, .combined_irq(comb),
        .evt(evo[0]), .evt_count(sink_cnt), .irq_seen(sink_irq));
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Outputs are sampled 1 ns after the edge so their updates have landed.
    task pulse(input [18:0] e, input [18:0] x);
        begin
            @(posedge pclk);
            ev <= e;
            @(posedge pclk);
            ev <= 19'h00000;
            #1 `CHK(evo, x)
            @(posedge pclk);
            #1 `CHK(evo, 19'h00000)
        end
    endtask
    task rcase(input [8:0] c, input [8:0] x, input [1:0] rr,
        input [1:0] ad);
        begin
            @(posedge pclk);
            rc <= c;
            @(posedge pclk);
            rc <= 9'h000;
            #1 `CHK({rresp, abandon, dirty}, {rr, ad})
            `CHK(evo[18], rr == `CER_RESP_SLVERR)
            apb(0, `CER_OFF_IRQ_RAW, 0);
            `CHK(rd[8:0], x)
            apb(1, `CER_OFF_IRQ_CLR, 32'h000001FF);
        end
    endtask
    task results;
        begin
            if (n_mismatch == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        results;
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `CER_OFF_AUX_CTRL, 0);
        `CHK(rd, `CER_AUX_RESET)
        apb(0, `CER_OFF_IRQ_RAW, 0);
        `CHK({comb, rd}, 33'h0)
        apb(1, 12'h010, 32'hFFFFFFFF);
        apb(0, 12'h010, 0);
        `CHK({err, rd}, {1'b1, 32'h0})
        pulse(19'h00001, 19'h00000);
        apb(1, `CER_OFF_AUX_CTRL, 32'h00000001);
        for (i = 0; i < 19; i = i + 1)
            pulse(19'h00001 << i, 19'h00001 << i);
        pulse(19'h7FFFF, 19'h7FFFF);
        `CHK(sink_cnt, 8'h02)
        @(posedge pclk);
        sec <= 19'h7FFFF;
        pulse(19'h00006, 19'h00000);
        apb(0, `CER_OFF_DBG_CTRL, 0);
        `CHK(rd[`CER_DBG_SECURE_EN], 1'b0)
        sde <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(0, `CER_OFF_DBG_CTRL, 0);
        `CHK(rd[`CER_DBG_SECURE_EN], 1'b1)
        pulse(19'h00006, 19'h00006);
        // Parity of bytes 07,00,FF,00,01,00,03,00 from byte 0 upward.
        @(posedge pclk);
        dwd <= 64'h0003000100FF0007;
        twd <= 21'h000007;
        @(posedge pclk);
        #1 `CHK({dpar, tpar}, 9'h023)
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge pclk);
            cause <= 3'h1 << i;
            @(posedge pclk);
            cause <= 3'h0;
            repeat (4) @(posedge pclk);
            xirq = (i == 0) ? 9'h100 : 9'h001 << (i - 1);
            #1 `CHK({irq, comb, sink_irq}, {xirq, 2'h3})
            apb(1, `CER_OFF_IRQ_CLR, 32'h000001FF);
            repeat (2) @(posedge pclk);
            #1 `CHK({irq, comb}, 10'h000)
        end
        rcase(9'h009, 9'h080, `CER_RESP_SLVERR, 2'h0);
        rcase(9'h011, 9'h088, `CER_RESP_SLVERR, 2'h0);
        rcase(9'h085, 9'h042, `CER_RESP_OKAY, 2'h0);
        rcase(9'h121, 9'h008, `CER_RESP_OKAY, 2'h0);
        rcase(9'h111, 9'h004, `CER_RESP_OKAY, 2'h0);
        rcase(9'h105, 9'h040, `CER_RESP_OKAY, 2'h0);
        rcase(9'h123, 9'h020, `CER_RESP_OKAY, 2'h0);
        rcase(9'h189, 9'h080, `CER_RESP_OKAY, 2'h2);
        rcase(9'h1D3, 9'h010, `CER_RESP_OKAY, 2'h1);
        results;
    end
endmodule
